// file: asp_checker.sv
// Checker for the serial framing and spacing produced by the controller.
`timescale 1ns/1ps
`default_nettype none
module asp_checker #(
    parameter int NV_WAIT_CYCLES = 50
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic [4:0]  rises;
    logic [15:0] sh;
    logic [19:0] idle;
    logic        cs_q;
    logic        sclk_q;
    logic        rd_prev;
    logic        wr_prev;
    wire logic   rise = spi_sclk && !sclk_q && !spi_cs_n;

    // Idle count starts saturated, so the first frame after reset owes no gap.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_q    <= 1'b1;
            sclk_q  <= 1'b0;
            rises   <= 5'h00;
            sh      <= 16'h0000;
            idle    <= 20'hfffff;
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end
        else
        begin
            cs_q   <= spi_cs_n;
            sclk_q <= spi_sclk;
            idle   <= !spi_cs_n ? 20'h0 : (idle == 20'hfffff) ? idle : idle + 20'h1;
            rises  <= spi_cs_n ? 5'h00 : rises + 5'(rise);
            if (rise)
                sh <= {sh[14:0], spi_mosi};
            if (spi_cs_n && !cs_q)
            begin
                rd_prev <= (rises == 5'h10) && (sh[15:13] == 3'h2);
                wr_prev <= (rises == 5'h10) && (sh[15:13] == 3'h4);
            end
        end
    end

    property p_lead;
        $fell(spi_cs_n) |-> ##1 $stable(spi_sclk) [*6];
    endproperty
    a_lead: assert property (p_lead) else $error("sclk moved too soon after select");
    property p_half;
        $changed(spi_sclk) && !spi_cs_n |=> ($stable(spi_sclk) || spi_cs_n) [*3];
    endproperty
    a_half: assert property (p_half) else $error("sclk half period too short");
    property p_mosi_fall;
        !spi_cs_n && !$past(spi_cs_n) && $changed(spi_mosi) |-> $fell(spi_sclk);
    endproperty
    a_mosi_fall: assert property (p_mosi_fall) else $error("mosi changed off a falling edge");
    property p_mosi_hold;
        $rose(spi_sclk) && !spi_cs_n |-> $stable(spi_mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at a sampling edge");
    property p_count;
        $rose(spi_cs_n) |-> (rises == 5'h10) || (rises == 5'h08);
    endproperty
    a_count: assert property (p_count) else $error("frame length not 16 or 8 clocks");
    property p_gap;
        $fell(spi_cs_n) |-> idle >= 20'd6;
    endproperty
    a_gap: assert property (p_gap) else $error("select idle below angle gap");
    property p_reg_gap;
        $fell(spi_cs_n) && rd_prev |-> idle >= 20'd30;
    endproperty
    a_reg_gap: assert property (p_reg_gap) else $error("select idle below register gap");
    property p_nv;
        $fell(spi_cs_n) && wr_prev |-> idle >= 20'(NV_WAIT_CYCLES);
    endproperty
    a_nv: assert property (p_nv) else $error("second frame before programming wait");
    property p_rd_zero;
        $rose(spi_cs_n) && rises == 5'h10 && sh[15:13] == 3'h2 |-> sh[7:0] == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read request low byte not zero");

    c_short: cover property ($rose(spi_cs_n) && rises == 5'h08);
    c_write: cover property ($fell(spi_cs_n) && wr_prev);
    c_mode3: cover property ($fell(spi_cs_n) && spi_sclk);
endmodule : asp_checker

bind asp_ctrl asp_checker #(.NV_WAIT_CYCLES(NV_WAIT_CYCLES)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));
`default_nettype wire

// file: asp_ctrl.sv
// AHB-Lite controlled SPI controller that drives the angle sensor port.
`timescale 1ns/1ps
`default_nettype none

module asp_ctrl #(
    parameter int NV_WAIT_CYCLES   = asp_pkg::NV_WAIT_CYC_DEFAULT,
    parameter int SCLK_HALF_CYCLES = asp_pkg::SCLK_HALF_DEFAULT
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             spi_cs_n,
    output logic             spi_sclk,
    output logic             spi_mosi,
    input  wire logic        spi_miso
);
    import asp_pkg::*;

    // Sampling happens on a synchronised copy, so a half period must cover two sync
    // stages plus the target's output delay; four cycles leave a margin.
    localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(SCLK_HALF_CYCLES);
    localparam logic [CNT_W-1:0] NV_CYC   = CNT_W'(NV_WAIT_CYCLES);

    logic             bus_wr;
    logic [7:0]       bus_addr;
    logic             next_bus_wr;
    logic [7:0]       next_bus_addr;
    logic [31:0]      next_hrdata;
    logic             addr_phase;

    asp_state_t       state;
    asp_state_t       next_state;
    asp_cmd_t         cmd;
    asp_cmd_t         next_cmd;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] next_idle_cnt;
    logic [CNT_W-1:0] last_need;
    logic [CNT_W-1:0] next_last_need;
    logic [CNT_W-1:0] cur_need;
    logic [CNT_W-1:0] need;
    logic [4:0]       bit_cnt;
    logic [4:0]       next_bit_cnt;
    logic [4:0]       frame_bits;
    logic             frame2;
    logic             next_frame2;
    logic [15:0]      tx;
    logic [15:0]      next_tx;
    logic [15:0]      rx;
    logic [15:0]      next_rx;
    logic [15:0]      result;
    logic [15:0]      next_result;
    logic             done;
    logic             next_done;
    logic             ack_ok;
    logic             next_ack_ok;
    logic             next_cs_n;
    logic             next_sclk;
    logic             next_mosi;
    logic             miso_meta;
    logic             miso_s;
    logic             ctrl_wr;
    logic             done_clr;
    logic             busy;

    assign busy       = (state != ST_IDLE);
    assign addr_phase = hsel && hready && htrans[1];
    assign ctrl_wr    = bus_wr && (bus_addr == REG_CTRL);
    assign done_clr   = bus_wr && (bus_addr == REG_STATUS) && hwdata[STAT_DONE_BIT];

    // The target drives its data pin on the serial clock and on select edges, never on ours.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            miso_meta <= 1'b0;
            miso_s    <= 1'b0;
        end
        else if (ce)
        begin
            miso_meta <= spi_miso;
            miso_s    <= miso_meta;
        end
    end

    always_comb
    begin
        next_bus_wr   = addr_phase && hwrite;
        next_bus_addr = addr_phase ? haddr[7:0] : bus_addr;
        next_hrdata   = hrdata;
        if (addr_phase && !hwrite)
        begin
            if (haddr[7:0] == REG_CTRL)
            begin
                next_hrdata = {8'h00, cmd.wdata, 3'h0, cmd.addr, 4'h0, cmd.mode3, cmd.short_rd, cmd.op};
            end
            else if (haddr[7:0] == REG_STATUS)
            begin
                next_hrdata = {29'h0, ack_ok, done, busy};
            end
            else if (haddr[7:0] == REG_RESULT)
            begin
                next_hrdata = {16'h0000, result};
            end
            else
            begin
                next_hrdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_wr    <= 1'b0;
            bus_addr  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (ce)
        begin
            bus_wr    <= next_bus_wr;
            bus_addr  <= next_bus_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb
    begin
        next_state     = state;
        next_cmd       = cmd;
        next_cnt       = cnt;
        next_last_need = last_need;
        next_bit_cnt   = bit_cnt;
        next_frame2    = frame2;
        next_tx        = tx;
        next_rx        = rx;
        next_result    = result;
        next_ack_ok    = ack_ok;
        next_cs_n      = spi_cs_n;
        next_sclk      = spi_cs_n ? cmd.mode3 : spi_sclk;
        next_mosi      = spi_mosi;
        next_done      = done && !done_clr;
        next_idle_cnt  = idle_cnt;
        if (spi_cs_n && (idle_cnt != {CNT_W{1'b1}}))
        begin
            next_idle_cnt = idle_cnt + 20'h00001;
        end
        cur_need   = (cmd.op == OP_ANGLE) ? ANGLE_GAP_CYC : REG_GAP_CYC;
        need       = (last_need > cur_need) ? last_need : cur_need;
        frame_bits = ((cmd.op == OP_ANGLE) && cmd.short_rd) ? SHORT_BITS : FULL_BITS;
        case (state)
            ST_IDLE:
            begin
                next_sclk = cmd.mode3;
                if (ctrl_wr)
                begin
                    next_cmd.op       = hwdata[CTRL_OP_LSB +: 2];
                    next_cmd.short_rd = hwdata[CTRL_SHORT_BIT];
                    next_cmd.mode3    = hwdata[CTRL_MODE3_BIT];
                    next_cmd.addr     = hwdata[CTRL_ADDR_LSB +: 5];
                    next_cmd.wdata    = hwdata[CTRL_DATA_LSB +: 8];
                    next_frame2       = 1'b0;
                    next_sclk         = hwdata[CTRL_MODE3_BIT];
                    if (hwdata[CTRL_OP_LSB +: 2] == OP_WRREG)
                    begin
                        next_tx = {CODE_WRITE, hwdata[CTRL_ADDR_LSB +: 5], hwdata[CTRL_DATA_LSB +: 8]};
                    end
                    else if (hwdata[CTRL_OP_LSB +: 2] == OP_RDREG)
                    begin
                        next_tx = {CODE_READ, hwdata[CTRL_ADDR_LSB +: 5], 8'h00};
                    end
                    else
                    begin
                        next_tx = 16'h0000;
                    end
                    next_state = ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (idle_cnt >= need)
                begin
                    next_cs_n    = 1'b0;
                    next_mosi    = tx[15];
                    next_cnt     = 20'h00001;
                    next_bit_cnt = 5'h00;
                    next_rx      = 16'h0000;
                    next_state   = ST_LEAD;
                end
            end
            ST_LEAD:
            begin
                next_cnt = cnt + 20'h00001;
                if (cnt >= CS_LEAD_CYC)
                begin
                    next_cnt   = 20'h00001;
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                next_cnt = cnt + 20'h00001;
                if (cnt >= HALF_CYC)
                begin
                    next_cnt  = 20'h00001;
                    next_sclk = !spi_sclk;
                    if (!spi_sclk)
                    begin
                        next_rx      = {rx[14:0], miso_s};
                        next_bit_cnt = bit_cnt + 5'h01;
                        if ((bit_cnt + 5'h01) == frame_bits)
                        begin
                            next_state = ST_TRAIL;
                        end
                    end
                    else
                    begin
                        next_mosi = tx[4'(15 - 32'(bit_cnt))];
                    end
                end
            end
            ST_TRAIL:
            begin
                next_cnt = cnt + 20'h00001;
                if (cnt >= CS_TRAIL_CYC)
                begin
                    next_cs_n     = 1'b1;
                    next_mosi     = 1'b0;
                    next_idle_cnt = 20'h00000;
                    if ((cmd.op == OP_WRREG) && !frame2)
                    begin
                        next_last_need = NV_CYC;
                    end
                    else
                    begin
                        next_last_need = (cmd.op == OP_ANGLE) ? ANGLE_GAP_CYC : REG_GAP_CYC;
                    end
                    if ((cmd.op != OP_ANGLE) && !frame2)
                    begin
                        next_frame2 = 1'b1;
                        next_tx     = 16'h0000;
                        next_state  = ST_GAP;
                    end
                    else
                    begin
                        next_result = cmd.short_rd && (cmd.op == OP_ANGLE) ? {rx[7:0], 8'h00} : rx;
                        next_ack_ok = (cmd.op != OP_WRREG) || (rx[15:8] == cmd.wdata);
                        next_done   = 1'b1;
                        next_state  = ST_IDLE;
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            cmd       <= CMD_RESET;
            cnt       <= 20'h00000;
            idle_cnt  <= {CNT_W{1'b1}};
            last_need <= 20'h00000;
            bit_cnt   <= 5'h00;
            frame2    <= 1'b0;
            tx        <= 16'h0000;
            rx        <= 16'h0000;
            result    <= 16'h0000;
            done      <= 1'b0;
            ack_ok    <= 1'b0;
            spi_cs_n  <= 1'b1;
            spi_sclk  <= 1'b0;
            spi_mosi  <= 1'b0;
        end
        else if (ce)
        begin
            state     <= next_state;
            cmd       <= next_cmd;
            cnt       <= next_cnt;
            idle_cnt  <= next_idle_cnt;
            last_need <= next_last_need;
            bit_cnt   <= next_bit_cnt;
            frame2    <= next_frame2;
            tx        <= next_tx;
            rx        <= next_rx;
            result    <= next_result;
            done      <= next_done;
            ack_ok    <= next_ack_ok;
            spi_cs_n  <= next_cs_n;
            spi_sclk  <= next_sclk;
            spi_mosi  <= next_mosi;
        end
    end

endmodule : asp_ctrl
`default_nettype wire

// file: asp_ctrl_bench.sv
// Testbench that drives the controller over its register bus against the sensor model.
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_bench;
    import asp_pkg::*;
    logic             core_clk;
    logic             ce;
    logic             rst_n;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    logic [15:0]      angle;
    logic [2:0]       field;
    logic [31:0]      q;
    logic [31:0]      st;
    wire logic        hready;
    wire logic        hresp;
    wire logic [31:0] hrdata;
    wire logic        cs_n;
    wire logic        sclk;
    wire logic        mosi;
    wire logic        miso;
    int               err_total;
    int               checks;

    asp_ctrl #(.NV_WAIT_CYCLES(50), .SCLK_HALF_CYCLES(4)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso));
    asp_sensor #(.ANGLE_BITS(12), .NV_NS(1000)) u_sensor (.cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .angle(angle), .field(field), .miso(miso));

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("Checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        @(posedge core_clk);
        while (hready !== 1'b1)
            @(posedge core_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'b1)
            @(posedge core_clk);
        r = hrdata;
    endtask : bus

    task automatic finish(output logic [31:0] res, output logic [31:0] s);
        logic [31:0] z;
        bus(1'b0, REG_STATUS, 32'h0, s);
        while (s[STAT_DONE_BIT] !== 1'b1)
            bus(1'b0, REG_STATUS, 32'h0, s);
        bus(1'b0, REG_RESULT, 32'h0, res);
        bus(1'b1, REG_STATUS, 32'h2, z);
    endtask : finish

    task automatic run(input logic [31:0] c, output logic [31:0] res, output logic [31:0] s);
        logic [31:0] z;
        bus(1'b1, REG_CTRL, c, z);
        finish(res, s);
    endtask : run

    initial
    begin
        err_total = 0;
        checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        angle = 16'ha5c3;
        field = 3'h0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        chk("cs_n", {31'h0, cs_n}, 32'h1);
        chk("sclk", {31'h0, sclk}, 32'h0);
        bus(1'b0, 8'h0c, 32'h0, q);
        chk("unmapped", q, 32'h0);
        run(32'h0000_0000, q, st);
        chk("angle_full", q, 32'h0000_a5c0);
        chk("status_done", st, (32'h1 << STAT_ACK_BIT) | (32'h1 << STAT_DONE_BIT));
        run(32'h0000_000c, q, st);
        chk("angle_short", q, 32'h0000_a500);
        bus(1'b0, REG_CTRL, 32'h0, q);
        chk("ctrl_readback", q, 32'h0000_000c);
        // A command written while busy must not replace the running one.
        bus(1'b1, REG_CTRL, 32'h0000_0000, q);
        bus(1'b1, REG_CTRL, 32'h0000_0901, q);
        finish(q, st);
        chk("busy_ignored", q, 32'h0000_a5c0);
        // Holding the clock enable low in mid-frame must freeze the link without spoiling the result.
        bus(1'b1, REG_CTRL, 32'h0000_0000, q);
        repeat (20) @(posedge core_clk);
        ce <= 1'b0;
        repeat (2) @(posedge core_clk);
        st = {29'h0, cs_n, sclk, mosi};
        repeat (40) @(posedge core_clk);
        chk("ce_cs", {31'h0, cs_n}, 32'h0);
        chk("ce_hold", {29'h0, cs_n, sclk, mosi}, st);
        ce <= 1'b1;
        finish(q, st);
        chk("ce_angle", q, 32'h0000_a5c0);
        run(32'h0080_0902, q, st);
        chk("wr_echo", q, 32'h0000_8000);
        chk("wr_ack", {31'h0, st[STAT_ACK_BIT]}, 32'h1);
        run(32'h0000_090d, q, st);
        chk("rd_dir", q, 32'h0000_8000);
        run(32'h0000_0401, q, st);
        chk("rd_default4", q, 32'h0000_c000);
        run(32'h0000_050d, q, st);
        chk("rd_default5", q, 32'h0000_0f00);
        run(32'h0074_0602, q, st);
        chk("wr_thresh", q, 32'h0000_7400);
        field <= 3'h6;
        run(32'h0000_1b01, q, st);
        chk("field_high", q, 32'h0000_8000);
        field <= 3'h1;
        run(32'h0000_1b01, q, st);
        chk("field_low", q, 32'h0000_4000);
        field <= 3'h4;
        run(32'h0000_1b01, q, st);
        chk("field_none", q, 32'h0000_0000);
        end_sim();
    end

    initial
    begin
        #1000000;
        err_total++;
        end_sim();
    end
endmodule : asp_ctrl_bench
`default_nettype wire

// file: asp_pkg.sv
// Constants and types shared by the angle sensor port controller.
package asp_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int CNT_W         = 20;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;

    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_SHORT_BIT = 2;
    localparam int CTRL_MODE3_BIT = 3;
    localparam int CTRL_ADDR_LSB  = 8;
    localparam int CTRL_DATA_LSB  = 16;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_ACK_BIT   = 2;

    localparam logic [1:0] OP_ANGLE = 2'h0;
    localparam logic [1:0] OP_RDREG = 2'h1;
    localparam logic [1:0] OP_WRREG = 2'h2;

    localparam logic [2:0] CODE_READ  = 3'h2;
    localparam logic [2:0] CODE_WRITE = 3'h4;

    localparam logic [4:0] FULL_BITS  = 5'h10;
    localparam logic [4:0] SHORT_BITS = 5'h08;

    localparam int ANGLE_GAP_TIME_NS    = 150;
    localparam int REG_READ_GAP_TIME_NS = 750;
    localparam int CS_LEAD_NS           = 80;
    localparam int CS_TRAIL_NS          = 25;
    localparam int NV_PROGRAM_WAIT_MS   = 20;

    localparam logic [CNT_W-1:0] ANGLE_GAP_CYC =
        CNT_W'((ANGLE_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] REG_GAP_CYC =
        CNT_W'((REG_READ_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CS_LEAD_CYC =
        CNT_W'((CS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CS_TRAIL_CYC =
        CNT_W'((CS_TRAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int NV_WAIT_CYC_DEFAULT = (NV_PROGRAM_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_DEFAULT   = 4;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_GAP   = 5'b00010,
        ST_LEAD  = 5'b00100,
        ST_SHIFT = 5'b01000,
        ST_TRAIL = 5'b10000
    } asp_state_t;

    typedef struct packed {
        logic [7:0] wdata;
        logic [4:0] addr;
        logic       mode3;
        logic       short_rd;
        logic [1:0] op;
    } asp_cmd_t;

    localparam asp_cmd_t CMD_RESET = '0;

endpackage : asp_pkg

// file: asp_sensor.sv
// Behavioural model of the angle sensor serial target.
`timescale 1ns/1ps
`default_nettype none
module asp_sensor #(
    parameter int ANGLE_BITS = 12,
    parameter int NV_NS      = 1000
) (
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic [15:0] angle,
    input  wire logic [2:0]  field,
    output logic             miso
);
    logic [7:0]  regs [0:31];
    logic [15:0] rx;
    logic [15:0] ow;
    logic [4:0]  cnt;
    logic [4:0]  idx;
    logic [4:0]  pa;
    logic [7:0]  old;
    logic [1:0]  pend;
    logic        mode3;
    realtime     nv_t;

    initial
    begin
        for (int i = 0; i < 32; i++)
            regs[i] = 8'h00;
        regs[4] = 8'hc0;
        regs[5] = 8'h0f;
        regs[6] = 8'h1c;
        pend = 2'h0;
        cnt = 5'h00;
        idx = 5'h00;
        nv_t = 0;
    end

    always @(negedge cs_n)
    begin
        mode3 = sclk;
        cnt = 5'h00;
        idx = 5'h00;
        if (pend == 2'h1 && pa == 5'h1b)
            ow = {field > regs[6][4:2], field < regs[6][7:5], 14'h0};
        else if (pend == 2'h1)
            ow = {regs[pa], 8'h00};
        else if (pend == 2'h2)
            ow = {($realtime >= nv_t) ? regs[pa] : old, 8'h00};
        else
            ow = angle & ~(16'hffff >> ANGLE_BITS);
    end

    always @(posedge sclk)
    begin
        if (!cs_n)
        begin
            rx = {rx[14:0], mosi};
            cnt = cnt + 5'h1;
        end
    end

    always @(negedge sclk)
    begin
        if (!cs_n)
            idx = cnt;
    end

    // Pull-down holds the line low whenever the output floats.
    assign miso = (cs_n || idx > 5'd15) ? 1'b0 : ow[4'd15 - idx[3:0]];

    always @(posedge cs_n)
    begin
        pend = 2'h0;
        pa = rx[12:8];
        if (cnt == 5'h10 && rx[15:13] == 3'h2)
            pend = 2'h1;
        else if (cnt == 5'h10 && rx[15:13] == 3'h4)
        begin
            pend = 2'h2;
            old = regs[pa];
            regs[pa] = rx[7:0];
            nv_t = $realtime + NV_NS;
        end
    end
endmodule : asp_sensor
`default_nettype wire
